/* File: verilog/adc_regs_pkg.sv */
// Package: offsets, field layout, codes and carriers for the converter input/result registers
package adc_regs_pkg;

    // Printed offsets are not all multiples of four: they are register indices
    localparam logic [5:0] IDX_POS_SELECT = 6'h0C;
    localparam logic [5:0] IDX_NEG_SELECT = 6'h0D;
    localparam logic [5:0] IDX_RESULT = 6'h10;
    localparam logic [5:0] IDX_SAMPLE = 6'h14;
    localparam logic [5:0] IDX_STAGING = 6'h18;
    localparam logic [5:0] IDX_WIN_LOW = 6'h1C;
    localparam logic [5:0] IDX_WIN_HIGH = 6'h1E;
    localparam int STAGING_BYTES = 3;
    localparam int IDX_BITS = 6;

    // Field layout of the input selection registers
    localparam int ROUTE_LSB = 6;
    localparam int ROUTE_MSB = 7;
    localparam int SELECT_MSB = 5;

    // Reset values
    localparam logic [1:0] ROUTE_RESET = 2'h0;
    localparam logic [5:0] SELECT_RESET = 6'h00;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0] STAGING_RESET = 8'h00;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [15:0] SAMPLE_RESET = 16'h0000;

    // Route encodings
    localparam logic [1:0] ROUTE_DIRECT = 2'h0;
    localparam logic [1:0] ROUTE_GAIN_AMPLIFIER = 2'h1;

    // Input selection codes
    localparam logic [5:0] SEL_PIN_LOW_LAST = 6'h0B;
    localparam logic [5:0] SEL_PIN_HIGH_FIRST = 6'h10;
    localparam logic [5:0] SEL_POS_PIN_HIGH_LAST = 6'h1E;
    localparam logic [5:0] SEL_PIN_HIGH_LAST = 6'h1F;
    localparam logic [5:0] SEL_GROUND = 6'h30;
    localparam logic [5:0] SEL_SUPPLY_TENTH_SOURCE = 6'h31;
    localparam logic [5:0] SEL_TEMPERATURE_SENSOR_SOURCE = 6'h32;
    localparam logic [5:0] SEL_DAC_OUTPUT_SOURCE = 6'h38;
    localparam logic [5:0] SEL_COMPARATOR0_DAC_REFERENCE = 6'h39;
    localparam logic [5:0] SEL_COMPARATOR1_DAC_REFERENCE = 6'h3A;

    // Conversion result carried from the core
    typedef struct packed {
        logic valid;
        logic final_value;
        logic [31:0] value;
    } result_t;

    // Settings handed to the analog front end and window comparator
    typedef struct packed {
        logic [1:0] route;
        logic [5:0] pos_select;
        logic [5:0] neg_select;
        logic [15:0] win_low;
        logic [15:0] win_high;
    } front_end_t;

    // Window compare value and its strobe
    typedef struct packed {
        logic strobe;
        logic [15:0] value;
    } window_sample_t;

endpackage

/* File: verilog/staging_bytes.sv */
// Staging byte store for atomic access to wide registers
`timescale 1ns/10ps

module staging_bytes #(
    parameter int DEPTH = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [1:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic [DEPTH*8-1:0] all_o
);
    import adc_regs_pkg::*;

    logic [7:0] mem_reg [DEPTH];

    if (DEPTH < 1 || DEPTH > 4) begin : g_bad_depth
        $error("staging_bytes: DEPTH must be 1 to 4");
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_byte
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mem_reg[g] <= STAGING_RESET;
            end else if (wr_en_i && wr_addr_i == 2'(g)) begin
                mem_reg[g] <= wr_data_i;
            end
        end
        assign all_o[g*8 +: 8] = mem_reg[g];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= STAGING_RESET;
        end else if (int'(rd_addr_i) < DEPTH) begin
            rd_data_o <= mem_reg[rd_addr_i];
        end else begin
            rd_data_o <= STAGING_RESET;
        end
    end

endmodule

/* File: verilog/adc_input_result_window_regs.sv */
// Converter input selection, result, sample, staging and window threshold registers
`timescale 1ns/10ps

module adc_input_result_window_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave, one byte register per word
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter core side
    input wire adc_regs_pkg::result_t result_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_i,
    input wire logic monitor_sample_i,
    output adc_regs_pkg::front_end_t front_end_o,
    output adc_regs_pkg::window_sample_t window_o,
    output logic select_reserved_o
);
    import adc_regs_pkg::*;

    // ==========================================================
    // Bus decode
    logic req;
    logic wr_req;
    logic rd_req;
    logic [IDX_BITS-1:0] idx;
    logic lane0;
    logic use_stage;
    logic rd_stage_pending_reg;

    // A staging read is held off one cycle while the store's read register loads
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !rd_stage_pending_reg;
    assign idx = wb_adr_i[7:2];
    assign lane0 = wb_sel_i[0];
    assign wr_req = req && wb_we_i && lane0;
    assign rd_req = req && !wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= (req && !(rd_req && use_stage)) || rd_stage_pending_reg;
        end
    end

    // ==========================================================
    // Captured result and sample from the core
    logic [31:0] result_reg;
    logic [15:0] sample_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_reg <= RESULT_RESET;
        end else if (result_i.valid) begin
            result_reg <= result_i.value;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_reg <= SAMPLE_RESET;
        end else if (sample_valid_i) begin
            sample_reg <= sample_i;
        end
    end

    // ==========================================================
    // Input selection and shared route
    logic [1:0] route_reg;
    logic [5:0] pos_select_reg;
    logic [5:0] neg_select_reg;
    logic wr_pos;
    logic wr_neg;

    assign wr_pos = wr_req && idx == IDX_POS_SELECT;
    assign wr_neg = wr_req && idx == IDX_NEG_SELECT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_reg <= ROUTE_RESET;
        end else if (wr_pos || wr_neg) begin
            route_reg <= wb_dat_i[ROUTE_MSB:ROUTE_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_select_reg <= SELECT_RESET;
        end else if (wr_pos) begin
            pos_select_reg <= wb_dat_i[SELECT_MSB:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            neg_select_reg <= SELECT_RESET;
        end else if (wr_neg) begin
            neg_select_reg <= wb_dat_i[SELECT_MSB:0];
        end
    end

    // Reserved-code detection for the settings
    function automatic logic pin_code_ok(input logic [5:0] c, input logic [5:0] high_last);
        pin_code_ok = (c <= SEL_PIN_LOW_LAST) || (c >= SEL_PIN_HIGH_FIRST && c <= high_last);
    endfunction

    logic route_ok;
    logic pos_ok;
    logic neg_ok;

    assign route_ok = route_reg == ROUTE_DIRECT || route_reg == ROUTE_GAIN_AMPLIFIER;
    assign pos_ok = pin_code_ok(pos_select_reg, SEL_PIN_HIGH_LAST)
        || pos_select_reg == SEL_GROUND
        || pos_select_reg == SEL_SUPPLY_TENTH_SOURCE
        || pos_select_reg == SEL_TEMPERATURE_SENSOR_SOURCE
        || pos_select_reg == SEL_DAC_OUTPUT_SOURCE;
    assign neg_ok = pin_code_ok(neg_select_reg, SEL_PIN_HIGH_LAST)
        || neg_select_reg == SEL_GROUND
        || neg_select_reg == SEL_DAC_OUTPUT_SOURCE
        || neg_select_reg == SEL_COMPARATOR0_DAC_REFERENCE
        || neg_select_reg == SEL_COMPARATOR1_DAC_REFERENCE;

    // ==========================================================
    // Staging store and wide-register access
    logic stage_wr;
    logic [1:0] stage_wr_addr;
    logic [7:0] stage_wr_data;
    logic [7:0] stage_rd_data;
    logic [STAGING_BYTES*8-1:0] stage_all;
    logic [1:0] stage_rd_addr;
    logic sw_stage_wr;
    logic rd_result_low;
    logic rd_sample_low;
    logic [1:0] fill_cnt_reg;
    logic [23:0] fill_data_reg;
    logic [1:0] fill_addr_reg;
    logic thr_low_wr;

    assign sw_stage_wr = wr_req && idx >= IDX_STAGING
        && idx < IDX_STAGING + IDX_BITS'(STAGING_BYTES);
    assign thr_low_wr = wr_req && (idx == IDX_WIN_LOW || idx == IDX_WIN_HIGH);
    assign rd_result_low = rd_req && idx == IDX_RESULT;
    assign rd_sample_low = rd_req && idx == IDX_SAMPLE;
    assign stage_rd_addr = 2'(idx - IDX_STAGING);

    // A low-byte read stages the upper bytes one per cycle after the read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fill_cnt_reg <= 2'h0;
            fill_addr_reg <= 2'h0;
            fill_data_reg <= 24'h000000;
        end else if (rd_result_low) begin
            fill_cnt_reg <= 2'h3;
            fill_addr_reg <= 2'h0;
            fill_data_reg <= result_reg[31:8];
        end else if (rd_sample_low) begin
            fill_cnt_reg <= 2'h1;
            fill_addr_reg <= 2'h0;
            fill_data_reg <= {16'h0000, sample_reg[15:8]};
        end else if (fill_cnt_reg != 2'h0) begin
            fill_cnt_reg <= fill_cnt_reg - 2'h1;
            fill_addr_reg <= fill_addr_reg + 2'h1;
            fill_data_reg <= {8'h00, fill_data_reg[23:8]};
        end
    end

    // Upper byte k lands in staging byte k-1 for both wide registers
    logic [1:0] fill_addr;
    assign fill_addr = fill_addr_reg;

    always_comb begin
        stage_wr = 1'b0;
        stage_wr_addr = 2'h0;
        stage_wr_data = 8'h00;
        if (sw_stage_wr) begin
            stage_wr = 1'b1;
            stage_wr_addr = stage_rd_addr;
            stage_wr_data = wb_dat_i[7:0];
        end else if (thr_low_wr) begin
            // Threshold low bytes wait in staging byte 0 for the high-byte commit
            stage_wr = 1'b1;
            stage_wr_addr = 2'h0;
            stage_wr_data = wb_dat_i[7:0];
        end else if (fill_cnt_reg != 2'h0) begin
            stage_wr = 1'b1;
            stage_wr_addr = fill_addr;
            stage_wr_data = fill_data_reg[7:0];
        end
    end

    staging_bytes #(
        .DEPTH(STAGING_BYTES)
    ) u_staging (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(stage_wr),
        .wr_addr_i(stage_wr_addr),
        .wr_data_i(stage_wr_data),
        .rd_addr_i(stage_rd_addr),
        .rd_data_o(stage_rd_data),
        .all_o(stage_all)
    );

    // ==========================================================
    // Window thresholds: low byte lands in staging, high byte commits both
    logic [15:0] win_low_reg;
    logic [15:0] win_high_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_low_reg <= THRESHOLD_RESET;
        end else if (wr_req && idx == IDX_WIN_LOW + IDX_BITS'(1)) begin
            win_low_reg <= {wb_dat_i[7:0], stage_all[7:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_high_reg <= THRESHOLD_RESET;
        end else if (wr_req && idx == IDX_WIN_HIGH + IDX_BITS'(1)) begin
            win_high_reg <= {wb_dat_i[7:0], stage_all[7:0]};
        end
    end

    // ==========================================================
    // Read mux, registered
    logic [7:0] rd_byte;

    assign use_stage = idx >= IDX_STAGING && idx < IDX_STAGING + IDX_BITS'(STAGING_BYTES);

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            IDX_POS_SELECT: rd_byte = {route_reg, pos_select_reg};
            IDX_NEG_SELECT: rd_byte = {route_reg, neg_select_reg};
            IDX_RESULT: rd_byte = result_reg[7:0];
            IDX_RESULT + 6'h01: rd_byte = result_reg[15:8];
            IDX_RESULT + 6'h02: rd_byte = result_reg[23:16];
            IDX_RESULT + 6'h03: rd_byte = result_reg[31:24];
            IDX_SAMPLE: rd_byte = sample_reg[7:0];
            IDX_SAMPLE + 6'h01: rd_byte = sample_reg[15:8];
            IDX_WIN_LOW: rd_byte = win_low_reg[7:0];
            IDX_WIN_LOW + 6'h01: rd_byte = win_low_reg[15:8];
            IDX_WIN_HIGH: rd_byte = win_high_reg[7:0];
            IDX_WIN_HIGH + 6'h01: rd_byte = win_high_reg[15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    // Staging reads answer one cycle later, once the store's read register has loaded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_stage_pending_reg <= 1'b0;
        end else begin
            rd_stage_pending_reg <= rd_req && use_stage;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_stage_pending_reg) begin
            wb_dat_o <= {24'h000000, stage_rd_data};
        end else if (rd_req) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end

    // ==========================================================
    // Outputs toward the front end and the window comparator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            front_end_o <= '0;
            select_reserved_o <= 1'b0;
        end else begin
            front_end_o <= '{route: route_reg, pos_select: pos_select_reg,
                neg_select: neg_select_reg, win_low: win_low_reg, win_high: win_high_reg};
            select_reserved_o <= !(route_ok && pos_ok && neg_ok);
        end
    end

    // With monitor_sample_i low only final accumulated results reach the comparator; with it high, samples do
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            window_o <= '0;
        end else if (monitor_sample_i) begin
            window_o <= '{strobe: sample_valid_i, value: sample_i};
        end else begin
            window_o <= '{strobe: result_i.valid && result_i.final_value,
                value: result_i.value[15:0]};
        end
    end

    // ==========================================================
    // Assertions
    a_route_shared: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_neg |=> route_reg == $past(wb_dat_i[ROUTE_MSB:ROUTE_LSB]))
        else $error("route not updated by negative select write");
    a_route_same_view: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && idx == IDX_POS_SELECT && !wb_we_i) |=> wb_dat_o[7:6] == route_reg)
        else $error("route read differs");
    a_route_code: assert property (@(posedge clk_i) disable iff (rst_i)
        !route_ok |=> select_reserved_o)
        else $error("reserved route not flagged");
    a_neg_ground: assert property (@(posedge clk_i) disable iff (rst_i)
        (neg_select_reg == SEL_GROUND && route_ok && pos_ok) |=> !select_reserved_o)
        else $error("ground flagged reserved");
    a_neg_pin_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        (neg_select_reg == 6'h0C) |=> select_reserved_o)
        else $error("gap code not reserved");
    a_result_byte: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_req && idx == IDX_RESULT + 6'h03)
        |=> wb_dat_o == {24'h000000, $past(result_reg[31:24])})
        else $error("result byte 3 wrong");
    a_sample_high: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_req && idx == IDX_SAMPLE + 6'h01) |=> wb_dat_o[7:0] == $past(sample_reg[15:8]))
        else $error("sample high byte wrong");
    a_stage_fill: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_result_low && !sw_stage_wr) |-> ##4 stage_all == $past(result_reg[31:8], 4))
        else $error("staging not filled from result");
    a_sample_stage: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_sample_low && !sw_stage_wr) |-> ##2 stage_all[7:0] == $past(sample_reg[15:8], 2))
        else $error("staging not filled from sample");
    a_win_low_commit: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_req && idx == IDX_WIN_LOW + 6'h01) |=> win_low_reg[15:8] == $past(wb_dat_i[7:0]))
        else $error("low threshold not committed");
    a_win_high_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr_req && idx == IDX_WIN_HIGH + 6'h01) |=> $stable(win_high_reg))
        else $error("high threshold changed without commit");
    a_final_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (!monitor_sample_i && result_i.valid && !result_i.final_value) |=> !window_o.strobe)
        else $error("partial accumulation compared");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    c_result_read: cover property (@(posedge clk_i) rd_result_low ##4 rd_req);
    c_win_commit: cover property (@(posedge clk_i)
        sw_stage_wr ##[1:8] (wr_req && idx == IDX_WIN_HIGH + 6'h01));
    c_route_gain: cover property (@(posedge clk_i) route_reg == ROUTE_GAIN_AMPLIFIER);
    c_final: cover property (@(posedge clk_i) window_o.strobe);

endmodule

/* File: dv/adc_input_result_window_regs_tb_top.sv */
// Self-checking bench for the converter input, result, staging and window register block
`timescale 1ns/10ps

module adc_input_result_window_regs_tb_top;
    import adc_regs_pkg::*;

    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    result_t result_i;
    logic sample_valid_i;
    logic [15:0] sample_i;
    logic monitor_sample_i;
    front_end_t front_end_o;
    window_sample_t window_o;
    logic select_reserved_o;
    int num_errors;
    int comparisons;
    logic [5:0] neg_codes [12] = '{6'h00, 6'h0B, 6'h0C, 6'h10, 6'h1F, 6'h20,
                                   6'h30, 6'h31, 6'h38, 6'h39, 6'h3A, 6'h3B};
    logic neg_bad [12] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
                           1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [5:0] pos_codes [8] = '{6'h1E, 6'h1F, 6'h31, 6'h32, 6'h39, 6'h0C, 6'h30, 6'h38};
    logic pos_bad [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    adc_input_result_window_regs u_adc_input_result_window_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .result_i(result_i),
        .sample_valid_i(sample_valid_i),
        .sample_i(sample_i),
        .monitor_sample_i(monitor_sample_i),
        .front_end_o(front_end_o),
        .window_o(window_o),
        .select_reserved_o(select_reserved_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; values read right after an edge are those sampled at it
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [7:0] din, output logic [31:0] dout);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, din};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        check(32'(wb_ack_o), 32'h00000001);
        dout = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] din);
        logic [31:0] d;
        bus(1'b1, adr, 4'h1, din, d);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, adr, 4'hF, 8'h00, d);
        check(d, {24'h000000, exp});
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask

    // Pulses a result or sample and watches the window strobe for a few cycles
    task automatic pulse(input logic smp, input logic fin, input logic [31:0] v,
                         output logic seen, output logic [15:0] wv);
        @(posedge clk_i);
        if (smp) begin
            sample_valid_i <= 1'b1;
            sample_i <= v[15:0];
        end else begin
            result_i <= {1'b1, fin, v};
        end
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        result_i.valid <= 1'b0;
        seen = 1'b0;
        wv = 16'h0000;
        repeat (6) begin
            @(posedge clk_i);
            if (window_o.strobe === 1'b1) begin
                seen = 1'b1;
                wv = window_o.value;
            end
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] adrs [15] = '{8'h30, 8'h34, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54,
                                  8'h60, 8'h64, 8'h68, 8'h70, 8'h74, 8'h78, 8'h7C};
        check(32'(front_end_o), 32'h00000000);
        check(32'(select_reserved_o), 32'h00000000);
        foreach (adrs[i]) rd(adrs[i], 8'h00);
        $display("test reset done");
    endtask

    task automatic t_route();
        logic [31:0] d;
        wr(8'h30, {ROUTE_GAIN_AMPLIFIER, 6'h05});
        rd(8'h34, {ROUTE_GAIN_AMPLIFIER, 6'h00});
        wr(8'h34, {ROUTE_DIRECT, 6'h1F});
        rd(8'h30, {ROUTE_DIRECT, 6'h05});
        wr(8'h34, {ROUTE_GAIN_AMPLIFIER, 6'h1F});
        settle();
        check(32'(front_end_o.route), 32'(ROUTE_GAIN_AMPLIFIER));
        check(32'(select_reserved_o), 32'h00000000);
        wr(8'h30, {2'h2, 6'h05});
        settle();
        check(32'(select_reserved_o), 32'h00000001);
        rd(8'h34, {2'h2, 6'h1F});
        bus(1'b1, 8'h30, 4'hE, 8'h07, d);
        rd(8'h30, {2'h2, 6'h05});
        wr(8'h30, 8'h00);
        $display("test route done");
    endtask

    task automatic t_codes();
        foreach (neg_codes[i]) begin
            wr(8'h34, {2'h0, neg_codes[i]});
            settle();
            check(32'(select_reserved_o), 32'(neg_bad[i]));
            check(32'(front_end_o.neg_select), 32'(neg_codes[i]));
        end
        wr(8'h34, 8'h00);
        foreach (pos_codes[i]) begin
            wr(8'h30, {2'h0, pos_codes[i]});
            settle();
            check(32'(select_reserved_o), 32'(pos_bad[i]));
            check(32'(front_end_o.pos_select), 32'(pos_codes[i]));
        end
        $display("test codes done");
    endtask

    task automatic t_result();
        logic seen;
        logic [15:0] wv;
        monitor_sample_i <= 1'b0;
        pulse(1'b0, 1'b1, 32'hA1B2C3D4, seen, wv);
        check(32'(seen), 32'h00000001);
        check(32'(wv), 32'h0000C3D4);
        rd(8'h40, 8'hD4);
        settle();
        pulse(1'b0, 1'b0, 32'h0F0E0D0C, seen, wv);
        check(32'(seen), 32'h00000000);
        rd(8'h60, 8'hC3);
        rd(8'h64, 8'hB2);
        rd(8'h68, 8'hA1);
        rd(8'h44, 8'h0D);
        rd(8'h48, 8'h0E);
        rd(8'h4C, 8'h0F);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h0C);
        $display("test result done");
    endtask

    task automatic t_sample();
        logic seen;
        logic [15:0] wv;
        monitor_sample_i <= 1'b1;
        pulse(1'b1, 1'b0, 32'h00005A3C, seen, wv);
        check(32'(seen), 32'h00000001);
        check(32'(wv), 32'h00005A3C);
        rd(8'h50, 8'h3C);
        settle();
        rd(8'h60, 8'h5A);
        rd(8'h54, 8'h5A);
        $display("test sample done");
    endtask

    task automatic t_thresh();
        wr(8'h70, 8'h11);
        rd(8'h60, 8'h11);
        settle();
        check(32'(front_end_o.win_low), 32'h00000000);
        wr(8'h74, 8'h22);
        settle();
        check(32'(front_end_o.win_low), 32'h00002211);
        rd(8'h70, 8'h11);
        rd(8'h74, 8'h22);
        wr(8'h60, 8'h33);
        rd(8'h60, 8'h33);
        wr(8'h7C, 8'h44);
        settle();
        check(32'(front_end_o.win_high), 32'h00004433);
        rd(8'h78, 8'h33);
        rd(8'h7C, 8'h44);
        wr(8'h64, 8'h5A);
        rd(8'h64, 8'h5A);
        $display("test thresholds done");
    endtask

    task automatic t_unmapped();
        wr(8'h80, 8'hAB);
        rd(8'h80, 8'h00);
        rd(8'h38, 8'h00);
        rd(8'hFC, 8'h00);
        $display("test unmapped done");
    endtask

    // ==========================================================
    // Verdict and sequence
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end

    initial begin
        num_errors = 0;
        comparisons = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        result_i = '0;
        sample_valid_i = 1'b0;
        sample_i = 16'h0000;
        monitor_sample_i = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_route();
        t_codes();
        t_result();
        t_sample();
        t_thresh();
        t_unmapped();
        report_and_stop();
    end

endmodule
